// >>> verilog/bsm_cycle_master.sv
// Contract
// - an acknowledged cycle lasts at least three output clocks
// - an input level meeting the window is recognised on that falling edge
// - read data is latched one falling edge after acknowledge is recognised
// - acknowledge at the S2 falling edge gives a cycle without waits
// - quick end finishes the transfer in two clocks, internally terminated
// - quick end overrides the acknowledge delay and uses no waits
// - quick end cycles assert the data strobe for reads only
// - read S0 drives address, function code, size, direction high
// - read S1 asserts both address strobe and data strobe
// - acknowledge at S2 latches at S4, else waits resample each falling edge
// - at S4 falling edge read data latched and port width sampled
// - S5 negates strobes, holds address, direction, size, function code
// - write S0 drives address, function code, size, direction low
// - write asserts only address strobe in S1, drives data in S2
// - write asserts data strobe in S3, ends one clock after acknowledge
// - write S5 keeps address and data valid while strobes negate
// - wide acknowledge reports a 16-bit port, narrow an 8-bit port
// - bus error aborts the cycle, bus error with halt requests retry
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module bsm_cycle_master (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // requester side
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [`BSM_ADDR_W-1:0] REQ_ADDR,
    input wire logic [`BSM_FC_W-1:0] REQ_FC,
    input wire bsm_pkg::bsm_size_t REQ_SIZE,
    input wire logic [`BSM_DATA_W-1:0] REQ_WDATA,
    input wire logic REQ_INTERNAL_ACK,
    input wire logic [`BSM_DLY_W-1:0] REQ_ACK_DELAY,
    input wire logic REQ_QUICK_END,
    output logic RSP_VALID,
    output logic [`BSM_DATA_W-1:0] RSP_RDATA,
    output logic RSP_PORT_WIDE,
    output logic RSP_BUS_ERROR,
    output logic RSP_RETRY,
    // external bus side
    output logic SYSTEM_CLOCK_OUT,
    output logic [`BSM_ADDR_W-1:0] ADDR_OUT,
    output logic [`BSM_FC_W-1:0] FUNCTION_CODE,
    output bsm_pkg::bsm_size_t TRANSFER_SIZE,
    output logic READ_WRITE,
    output logic ADDRESS_STROBE_N,
    output logic DATA_STROBE_N,
    output logic [`BSM_DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N,
    input wire logic [`BSM_DATA_W-1:0] DATA_IN,
    input wire logic ACK_WIDE_PORT_N,
    input wire logic ACK_NARROW_PORT_N,
    input wire logic BUS_ERROR_IN_N,
    input wire logic HALT_N
);
    import bsm_pkg::*;

    localparam logic [`BSM_DATA_W+3:0] SYNC_RST = {4'hF, {`BSM_DATA_W{1'b0}}};

    bsm_regs_t state_r;
    bsm_regs_t state_nxt;
    logic [`BSM_DATA_W+3:0] pins_s;
    logic [`BSM_DATA_W-1:0] data_s;
    logic ack_wide_s;
    logic ack_narrow_s;
    logic bus_error_in_s;
    logic halt_s;
    logic int_ack;
    logic ack_rec;
    logic as_act;

    // all bus inputs cross two flops; the pair counts as the input setup time
    bsm_sync #(
        .RST_VAL(SYNC_RST)
    ) u_sync (
        .CLK_SYS(CLK_SYS),
        .RESET_N(RESET_N),
        .async_in({ACK_WIDE_PORT_N, ACK_NARROW_PORT_N, BUS_ERROR_IN_N, HALT_N, DATA_IN}),
        .sync_out(pins_s)
    );

    // unpack synchronised pins, active high from here on
    assign data_s = pins_s[`BSM_DATA_W-1:0];
    assign halt_s = ~pins_s[`BSM_DATA_W];
    assign bus_error_in_s = ~pins_s[`BSM_DATA_W+1];
    assign ack_narrow_s = ~pins_s[`BSM_DATA_W+2];
    assign ack_wide_s = ~pins_s[`BSM_DATA_W+3];

    // chip select acknowledge after its programmed number of waits
    assign int_ack = state_r.internal && (state_r.waits == state_r.delay);
    assign ack_rec = ack_wide_s || ack_narrow_s || int_ack;

    // next state; one state per half clock of the output clock
    always_comb begin
        state_nxt = state_r;
        state_nxt.clk_hi = ~state_r.clk_hi;
        state_nxt.rsp_valid = 1'b0;
        if (state_r.st != ST_IDLE && state_r.phases != `BSM_CNT_MAX) begin
            state_nxt.phases = state_r.phases + `BSM_CNT_ONE;
        end
        case (state_r.st)
            ST_IDLE: begin
                // start only so that S0 lands on a high output clock phase
                if (REQ_VALID && !state_r.clk_hi) begin
                    state_nxt.st = ST_S0;
                    state_nxt.write = REQ_WRITE;
                    state_nxt.quick = REQ_QUICK_END;
                    state_nxt.internal = REQ_INTERNAL_ACK && !REQ_QUICK_END;
                    state_nxt.delay = REQ_ACK_DELAY;
                    state_nxt.waits = '0;
                    state_nxt.addr = REQ_ADDR;
                    state_nxt.fc = REQ_FC;
                    state_nxt.size = REQ_SIZE;
                    state_nxt.wdata = REQ_WDATA;
                    state_nxt.rw = REQ_WRITE ? `BSM_RW_WRITE : `BSM_RW_READ;
                    state_nxt.rsp_err = 1'b0;
                    state_nxt.rsp_retry = 1'b0;
                    state_nxt.phases = `BSM_CNT_ONE;
                end
            end
            ST_S0: begin
                state_nxt.st = ST_S1;
            end
            ST_S1: begin
                // quick end skips the acknowledge sample entirely
                state_nxt.st = state_r.quick ? ST_S4 : ST_S2;
            end
            ST_S2, ST_W_HI: begin
                // falling edge at the end of this phase is the sample point
                if (ack_rec || bus_error_in_s) begin
                    state_nxt.st = ST_S3;
                    state_nxt.rsp_err = bus_error_in_s && !ack_rec;
                    state_nxt.rsp_retry = bus_error_in_s && !ack_rec && halt_s;
                end else begin
                    state_nxt.st = ST_W_LO;
                end
            end
            ST_W_LO: begin
                state_nxt.st = ST_W_HI;
                if (state_r.waits != '1) begin
                    state_nxt.waits = state_r.waits + 1'b1;
                end
            end
            ST_S3: begin
                state_nxt.st = ST_S4;
            end
            ST_S4: begin
                // one falling edge after recognition: data and port width
                state_nxt.st = ST_S5;
                state_nxt.rsp_wide = state_r.quick || state_r.internal || ack_wide_s;
                if (!state_r.write) begin
                    state_nxt.rdata = data_s;
                end
                // late bus error, legal one clock after the acknowledge
                if (!state_r.quick && bus_error_in_s) begin
                    state_nxt.rsp_err = 1'b1;
                    state_nxt.rsp_retry = halt_s;
                end
            end
            ST_S5: begin
                state_nxt.st = ST_IDLE;
                state_nxt.rsp_valid = 1'b1;
            end
            default: begin
                state_nxt.st = ST_IDLE;
            end
        endcase

        // pin levels follow the state being entered, so they are registered
        as_act = (state_nxt.st == ST_S1) || (state_nxt.st == ST_S2) ||
                 (state_nxt.st == ST_W_LO) || (state_nxt.st == ST_W_HI) ||
                 (state_nxt.st == ST_S3) || (state_nxt.st == ST_S4);
        state_nxt.as_n = as_act ? `BSM_PIN_ON : `BSM_PIN_OFF;
        if (!state_nxt.write) begin
            state_nxt.ds_n = as_act ? `BSM_PIN_ON : `BSM_PIN_OFF;
        end else if (!state_nxt.quick &&
                     (state_nxt.st == ST_S3 || state_nxt.st == ST_S4)) begin
            state_nxt.ds_n = `BSM_PIN_ON;
        end else begin
            state_nxt.ds_n = `BSM_PIN_OFF;
        end
        // write data from S2 through S5; quick writes skip S2, so from S1
        if (state_nxt.write &&
            ((state_nxt.st != ST_IDLE && state_nxt.st != ST_S0 &&
              state_nxt.st != ST_S1) ||
             (state_nxt.quick && state_nxt.st == ST_S1))) begin
            state_nxt.doe_n = `BSM_PIN_ON;
        end else begin
            state_nxt.doe_n = `BSM_PIN_OFF;
        end
    end

    // single register of all state; strobes negated and bus released at reset
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= '{st: ST_IDLE, rw: `BSM_RW_READ, as_n: `BSM_PIN_OFF,
                         ds_n: `BSM_PIN_OFF, doe_n: `BSM_PIN_OFF, default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs; address, size and code stay put until the next S0
    assign REQ_READY = (state_r.st == ST_IDLE) && !state_r.clk_hi;
    assign RSP_VALID = state_r.rsp_valid;
    assign RSP_RDATA = state_r.rdata;
    assign RSP_PORT_WIDE = state_r.rsp_wide;
    assign RSP_BUS_ERROR = state_r.rsp_err;
    assign RSP_RETRY = state_r.rsp_retry;
    assign SYSTEM_CLOCK_OUT = state_r.clk_hi;
    assign ADDR_OUT = state_r.addr;
    assign FUNCTION_CODE = state_r.fc;
    assign TRANSFER_SIZE = state_r.size;
    assign READ_WRITE = state_r.rw;
    assign ADDRESS_STROBE_N = state_r.as_n;
    assign DATA_STROBE_N = state_r.ds_n;
    assign DATA_OUT = state_r.wdata;
    assign DATA_OE_N = state_r.doe_n;

    // checks on the sequence

    sequence seq_tail;
        state_r.st == ST_S3 ##1 state_r.st == ST_S4 ##1 state_r.st == ST_S5;
    endsequence

    sequence seq_quick_tail;
        state_r.st == ST_S4 ##1 state_r.st == ST_S5 ##1 state_r.st == ST_IDLE;
    endsequence

    chk_min_length: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S5 && !state_r.quick) |-> state_r.phases >= `BSM_MIN_PHASES)
        else $error("acknowledged cycle shorter than three clocks");

    chk_edge_recog: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_W_HI && ack_rec) |=> state_r.st == ST_S3)
        else $error("acknowledge not taken on its wait edge");

    chk_read_latch: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S4 && !state_r.write) |=> state_r.rdata == $past(data_s))
        else $error("read data not latched at S4 edge");

    chk_no_waits: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S2 && ack_rec) |=> seq_tail ##1 RSP_VALID)
        else $error("wait inserted despite S2 acknowledge");

    chk_quick_len: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S5 && state_r.quick) |-> state_r.phases == `BSM_QUICK_PHASES)
        else $error("quick end cycle not two clocks");

    chk_quick_skip: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S1 && state_r.quick) |=> seq_quick_tail)
        else $error("quick end cycle waited or sampled acknowledge");

    chk_quick_ds: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.quick && state_r.write) |-> DATA_STROBE_N)
        else $error("data strobe asserted on quick write");

    chk_read_start: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S0 && !state_r.write) |-> READ_WRITE && ADDRESS_STROBE_N)
        else $error("read S0 direction or strobe wrong");

    chk_read_strobes: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S1 && !state_r.write) |-> !ADDRESS_STROBE_N && !DATA_STROBE_N)
        else $error("read S1 strobes not both asserted");

    chk_wait_insert: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S2 && !ack_rec && !bus_error_in_s) |=> state_r.st == ST_W_LO ##1
            state_r.st == ST_W_HI)
        else $error("wait state missing without acknowledge");

    chk_s5_hold: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S5) |-> ADDRESS_STROBE_N && DATA_STROBE_N &&
            $stable(ADDR_OUT) && $stable(READ_WRITE) && $stable(TRANSFER_SIZE))
        else $error("S5 strobes or hold signals wrong");

    chk_write_start: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S0 && state_r.write) |-> !READ_WRITE && ADDRESS_STROBE_N)
        else $error("write S0 direction not low");

    chk_write_s1s2: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S1 && state_r.write && !state_r.quick) |->
            !ADDRESS_STROBE_N && DATA_STROBE_N && DATA_OE_N ##1 !DATA_OE_N)
        else $error("write S1 or S2 drive wrong");

    chk_write_ds: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S3 && state_r.write) |-> !DATA_STROBE_N)
        else $error("write data strobe missing in S3");

    chk_write_hold: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S5 && state_r.write) |-> !DATA_OE_N && $stable(DATA_OUT) ##1
            DATA_OE_N)
        else $error("write data not held through S5");

    chk_port_width: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S4 && !state_r.quick && !state_r.internal) |=>
            RSP_PORT_WIDE == $past(ack_wide_s))
        else $error("port width not taken at S4");

    chk_late_error: assert property (
        @(posedge CLK_SYS) disable iff (!RESET_N)
        (state_r.st == ST_S4 && !state_r.quick && bus_error_in_s) |=> ##1
            RSP_VALID && RSP_BUS_ERROR && RSP_RETRY == $past(halt_s, 2))
        else $error("bus error not reported");

endmodule

`default_nettype wire

// >>> verilog/bsm_defs.svh
`ifndef BSM_DEFS_SVH
`define BSM_DEFS_SVH

// bus widths
`define BSM_ADDR_W 32
`define BSM_DATA_W 16
`define BSM_FC_W 4
`define BSM_SIZE_W 2

// internal acknowledge delay, counted in wait states
`define BSM_DLY_W 2

// phase counter, one count per half clock of the output clock
`define BSM_CNT_W 8
`define BSM_CNT_ONE 8'h01
`define BSM_CNT_MAX 8'hFF

// three output clocks per acknowledged cycle, two for quick end
`define BSM_MIN_PHASES 8'h06
`define BSM_QUICK_PHASES 8'h04

// system clock period, and half clocks of the output clock per cycle
`define BSM_CLK_PERIOD_NS 5
`define BSM_HALF_CLK_CYCLES 1

// pin levels
`define BSM_RW_READ 1'b1
`define BSM_RW_WRITE 1'b0
`define BSM_PIN_ON 1'b0
`define BSM_PIN_OFF 1'b1

`endif

// >>> verilog/bsm_pkg.sv
`include "bsm_defs.svh"

package bsm_pkg;

    // one state per half clock of the output clock; waits come in pairs
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_S0,
        ST_S1,
        ST_S2,
        ST_W_LO,
        ST_W_HI,
        ST_S3,
        ST_S4,
        ST_S5
    } bsm_state_t;

    typedef logic [`BSM_SIZE_W-1:0] bsm_size_t;

    typedef struct packed {
        bsm_state_t st;
        logic clk_hi;
        logic write;
        logic quick;
        logic internal;
        logic [`BSM_DLY_W-1:0] delay;
        logic [`BSM_DLY_W-1:0] waits;
        logic [`BSM_ADDR_W-1:0] addr;
        logic [`BSM_FC_W-1:0] fc;
        bsm_size_t size;
        logic [`BSM_DATA_W-1:0] wdata;
        logic rw;
        logic as_n;
        logic ds_n;
        logic doe_n;
        logic [`BSM_DATA_W-1:0] rdata;
        logic rsp_valid;
        logic rsp_wide;
        logic rsp_err;
        logic rsp_retry;
        logic [`BSM_CNT_W-1:0] phases;
    } bsm_regs_t;

    typedef struct packed {
        logic [`BSM_DATA_W+3:0] stage1;
        logic [`BSM_DATA_W+3:0] stage2;
    } bsm_sync_t;

endpackage

// >>> verilog/bsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module bsm_sync #(
    parameter logic [`BSM_DATA_W+3:0] RST_VAL = '0
) (
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    input wire logic [`BSM_DATA_W+3:0] async_in,
    output logic [`BSM_DATA_W+3:0] sync_out
);
    import bsm_pkg::*;

    bsm_sync_t sync_r;
    bsm_sync_t sync_nxt;

    // stage1 feeds stage2 only, per bit
    genvar gi;
    generate
        for (gi = 0; gi < `BSM_DATA_W + 4; gi = gi + 1) begin : g_bit
            always_comb begin
                sync_nxt.stage1[gi] = async_in[gi];
                sync_nxt.stage2[gi] = sync_r.stage1[gi];
            end
        end
    endgenerate

    // reset to the negated pin levels so no false acknowledge at start
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            sync_r <= '{stage1: RST_VAL, stage2: RST_VAL};
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r.stage2;

endmodule

`default_nettype wire

// >>> verilog/bsm_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tb/bsm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module bsm_slave_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [`BSM_ADDR_W-1:0] addr,
    input wire logic rw,
    input wire logic as_n,
    input wire logic [`BSM_DATA_W-1:0] wdata,
    input wire logic [2:0] ack_delay,
    input wire logic [1:0] ack_kind,
    input wire logic [1:0] err_kind,
    output logic [`BSM_DATA_W-1:0] rdata,
    output logic ack_wide_n,
    output logic ack_narrow_n,
    output logic bus_error_in_n,
    output logic halt_n,
    output logic [`BSM_DATA_W-1:0] stored
);
    logic [`BSM_ADDR_W-1:0] last_addr;
    logic busy;
    logic seen_as;
    int cnt;

    // decodes on the address change in S0, the way a synchronous chip select would
    always @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_addr = '0;
            busy = 1'b0;
            seen_as = 1'b0;
            cnt = 0;
            rdata = 16'hFFFF;
            {ack_wide_n, ack_narrow_n, bus_error_in_n, halt_n} = 4'hF;
            stored = 16'h0000;
        end else begin
            if (addr !== last_addr) begin
                last_addr = addr;
                busy = 1'b1;
                seen_as = 1'b0;
                cnt = 0;
                // fast memory: read data out straight from decode
                if (rw) rdata = addr[15:0] ^ 16'h5A3C;
            end else if (busy) begin
                cnt = cnt + 1;
            end
            if (busy && !as_n) seen_as = 1'b1;
            if (busy && seen_as && as_n) begin
                // strobes gone: store the lanes, then drop everything within a clock
                if (!rw) stored = wdata;
                busy = 1'b0;
                rdata = ~rdata;
                {ack_wide_n, ack_narrow_n, bus_error_in_n, halt_n} = 4'hF;
            end else if (busy && cnt >= ack_delay) begin
                // acks stay negated until the delay runs out, which is what forces waits
                // kind 3 acknowledges, then raises bus error one clock later
                ack_wide_n = !((err_kind == 2'h0 || err_kind == 2'h3) && ack_kind[0]);
                ack_narrow_n = !((err_kind == 2'h0 || err_kind == 2'h3) && ack_kind[1]);
                bus_error_in_n = (err_kind == 2'h0) || (err_kind == 2'h3 && cnt < ack_delay + 2);
                halt_n = (err_kind != 2'h2);
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsm_defs.svh"

module testbench;
    import bsm_pkg::*;
    logic clk_sys, reset_n, req_valid, req_ready, req_write, req_int_ack, req_quick;
    logic [`BSM_ADDR_W-1:0] req_addr, addr_out;
    logic [`BSM_FC_W-1:0] req_fc, fc_out;
    bsm_size_t req_size, size_out;
    logic [`BSM_DATA_W-1:0] req_wdata, rsp_rdata, dout, din, stored;
    logic [`BSM_DLY_W-1:0] req_delay;
    logic rsp_valid, rsp_wide, rsp_err, rsp_retry, sclk, rw, as_n, ds_n, doe_n;
    logic ackw_n, ackn_n, bus_error_in_n, halt_n;
    logic [2:0] s_delay;
    logic [1:0] s_kind, s_err;
    int seed = 37;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    bsm_cycle_master bsm_cycle_master_inst (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_FC(req_fc), .REQ_SIZE(req_size),
        .REQ_WDATA(req_wdata), .REQ_INTERNAL_ACK(req_int_ack), .REQ_ACK_DELAY(req_delay),
        .REQ_QUICK_END(req_quick), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
        .RSP_PORT_WIDE(rsp_wide), .RSP_BUS_ERROR(rsp_err), .RSP_RETRY(rsp_retry),
        .SYSTEM_CLOCK_OUT(sclk), .ADDR_OUT(addr_out), .FUNCTION_CODE(fc_out),
        .TRANSFER_SIZE(size_out), .READ_WRITE(rw), .ADDRESS_STROBE_N(as_n),
        .DATA_STROBE_N(ds_n), .DATA_OUT(dout), .DATA_OE_N(doe_n), .DATA_IN(din),
        .ACK_WIDE_PORT_N(ackw_n), .ACK_NARROW_PORT_N(ackn_n), .BUS_ERROR_IN_N(bus_error_in_n),
        .HALT_N(halt_n)
    );

    bsm_slave_model bsm_slave_model_inst (
        .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr_out), .rw(rw), .as_n(as_n),
        .wdata(dout), .ack_delay(s_delay), .ack_kind(s_kind), .err_kind(s_err), .rdata(din),
        .ack_wide_n(ackw_n), .ack_narrow_n(ackn_n), .bus_error_in_n(bus_error_in_n), .halt_n(halt_n),
        .stored(stored)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hung handshake ends the run instead of spinning forever
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // mode: 0 slave ack, 1 internal ack, 2 quick end, 3 bus error, 4 bus error with halt,
    // 5 slave ack followed one clock later by bus error
    function automatic int exp_waits(input int mode, input int dly);
        if (mode == 1) return dly;
        if (mode == 2) return 0;
        return (dly + 1) / 2;
    endfunction

    function automatic logic [15:0] exp_rdata(input logic [31:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction

    task automatic run_op(input logic wr, input int mode, input int dly, input logic [1:0] kind);
        logic [31:0] a;
        logic [15:0] wd;
        logic [3:0] fc;
        logic [1:0] sz;
        int w, lat, t, as_c, ds_c, oe_c, as_e;
        a = $random(seed);
        if (a == req_addr) a = ~a;
        wd = $random(seed);
        fc = $random(seed);
        sz = $random(seed);
        w = exp_waits(mode, dly);
        lat = (mode == 2) ? 5 : 7 + 2 * w;
        as_e = (mode == 2) ? 2 : 4 + 2 * w;
        as_c = 0;
        ds_c = 0;
        oe_c = 0;
        req_valid = 1'b1;
        {req_write, req_addr, req_fc, req_size, req_wdata} = {wr, a, fc, sz, wd};
        {req_int_ack, req_quick, req_delay} = {mode == 1, mode == 2, dly[1:0]};
        {s_delay, s_kind} = {dly[2:0], (mode == 0 || mode == 5) ? kind : 2'b00};
        s_err = (mode >= 3) ? 2'(mode - 2) : 2'h0;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        t = 1;
        while (rsp_valid !== 1'b1 && t < 300) begin
            check("addr_fc_size_rw", {addr_out, fc_out, size_out, rw}, {a, fc, sz, !wr});
            check("sclk", sclk, t[0]);
            if (t == 1) check("as_s0", as_n, 1'b1);
            if (t == 2) check("strobes_s1", {as_n, ds_n}, {1'b0, wr});
            if (t == lat - 1) check("strobes_s5", {as_n, ds_n}, 2'b11);
            if (doe_n === 1'b0) check("wdata", dout, wd);
            as_c += (as_n === 1'b0);
            ds_c += (ds_n === 1'b0);
            oe_c += (doe_n === 1'b0);
            @(negedge clk_sys);
            t++;
        end
        check("latency", t, lat);
        check("as_len", as_c, as_e);
        check("ds_len", ds_c, !wr ? as_e : (mode == 2) ? 0 : 2);
        check("oe_len", oe_c, !wr ? 0 : (mode == 2) ? 3 : 4 + 2 * w);
        check("err_retry", {rsp_err, rsp_retry}, {mode >= 3, mode == 4});
        if (mode < 3 || mode == 5) begin
            check("port_wide", rsp_wide, mode == 1 || mode == 2 || kind[0]);
        end
        if (mode < 3 && !wr) check("rdata", rsp_rdata, exp_rdata(a));
        if (wr) check("stored", stored, wd);
        @(negedge clk_sys);
        check("rsp_pulse", rsp_valid, 1'b0);
    endtask

    initial begin
        int i, m;
        reset_n = 1'b0;
        {req_valid, req_write, req_int_ack, req_quick} = 4'h0;
        {req_addr, req_fc, req_size, req_wdata, req_delay} = '0;
        {s_delay, s_kind, s_err} = '0;
        repeat (10) @(negedge clk_sys);
        check("reset_pins", {as_n, ds_n, doe_n, rw, sclk}, 5'b11110);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        // corners first: no waits, narrow and both acks, overridden delay, errors
        run_op(1'b0, 0, 0, 2'b01);
        run_op(1'b1, 0, 0, 2'b01);
        run_op(1'b0, 0, 4, 2'b10);
        run_op(1'b1, 0, 3, 2'b11);
        run_op(1'b0, 1, 3, 2'b00);
        run_op(1'b1, 1, 0, 2'b00);
        run_op(1'b0, 2, 3, 2'b00);
        run_op(1'b1, 2, 3, 2'b00);
        run_op(1'b0, 3, 1, 2'b00);
        run_op(1'b1, 4, 0, 2'b00);
        run_op(1'b0, 5, 1, 2'b01);
        run_op(1'b1, 5, 4, 2'b10);
        for (i = 0; i < 60; i++) begin
            m = {$random(seed)} % 6;
            run_op($random(seed), m, {$random(seed)} % ((m == 1 || m == 2) ? 4 : 5),
                2'(1 + {$random(seed)} % 3));
        end
        finish_test();
    end
endmodule
`default_nettype wire
